// ==== acfrx_pkg.sv ====
/*
  constants, state types and shared decoding for the character format and
  receive fifo control block. assumes nothing of its surroundings.
*/
`default_nettype none
package acfrx_pkg;
  // register indices, byte address is four times the index
  localparam logic [7:0] REG_FIFO = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h20;
  localparam logic [7:0] REG_MASK = 8'h21;
  localparam logic [7:0] REG_STAT = 8'h22;
  localparam logic [7:0] REG_TCR = 8'h26;
  localparam logic [7:0] REG_DATA_FORMAT_REG = 8'h27;
  localparam logic [7:0] REG_RFC = 8'h28;
  localparam logic [7:0] REG_CNTL = 8'h2A;
  localparam logic [7:0] REG_CNTH = 8'h2B;
  localparam logic [7:0] REG_RESET = 8'h00;
  // field positions
  localparam int DATA_FORMAT_REG_STOP = 5;
  localparam int DATA_FORMAT_REG_PAR = 3;
  localparam int DATA_FORMAT_REG_PARITY_ENABLE_BIT = 2;
  localparam int DATA_FORMAT_REG_CHL = 0;
  localparam int RFC_DPS = 6;
  localparam int RFC_FIFO_STATUS_FORMAT = 4;
  localparam int RFC_RFTH = 2;
  localparam int RFC_TERM_CHAR_DETECT_ENABLE = 0;
  localparam int CMD_RMC = 7;
  localparam int CMD_XF = 3;
  localparam int CNTH_DMA = 7;
  localparam int CNTH_CAS = 5;
  localparam int MASK_RPF = 0;
  localparam int MASK_TCD = 1;
  localparam int MASK_PE = 2;
  // register field masks for write storage
  localparam logic [7:0] DATA_FORMAT_REG_BITS = 8'h3F;
  localparam logic [7:0] RFC_BITS = 8'h5D;
  localparam logic [7:0] CNTH_BITS = 8'hBF;
  localparam logic [7:0] MASK_BITS = 8'h07;
  // fifo geometry
  localparam int FIFO_AW = 6;
  localparam logic [FIFO_AW:0] FIFO_DEPTH = 7'h40;
  // bit timing in system clocks
  localparam logic [4:0] BIT_RELOAD = 5'h0F;
  localparam logic [4:0] FIRST_SAMPLE = 5'h17;

  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_DATA = 2'b01, RX_PAR = 2'b11, RX_STOP = 2'b10} acfrx_rxst_t;
  typedef enum logic [2:0] {TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b011, TX_PAR = 3'b010,
    TX_STOP = 3'b110} acfrx_txst_t;

  // parity bit for a right-justified character
  function automatic logic acfrx_parity(input logic [1:0] fmt, input logic [7:0] d);
    logic p;
    p = 1'b0;
    unique case (fmt)
      2'b00: p = 1'b0;
      2'b01: p = ~^d;
      2'b10: p = ^d;
      2'b11: p = 1'b1;
    endcase
    return p;
  endfunction

  // character length code to bit count
  function automatic logic [3:0] acfrx_bits(input logic [1:0] len);
    return 4'h8 - {2'b00, len};
  endfunction
endpackage
`default_nettype wire

// ==== acfrx_mem.sv ====
/*
  receive fifo storage, one write and one registered read per clock.
  assumes the caller keeps the pointers apart.
*/
`timescale 1ns/1ps
`default_nettype none
module acfrx_mem (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic wrEn,
  input wire logic [acfrx_pkg::FIFO_AW-1:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [acfrx_pkg::FIFO_AW-1:0] rdAddr,
  output logic [7:0] rdData
);
  import acfrx_pkg::*;
  logic [7:0] mem [0:(1<<FIFO_AW)-1];

  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdData <= 8'h00;
    end else begin
      rdData <= mem[rdAddr];
    end
  end
endmodule
`default_nettype wire

// ==== acfrx_rx.sv ====
/*
  serial character receiver: start, data, optional parity, first stop bit.
  assumes the line input is synchronous to clk_sys and idles high.
*/
`timescale 1ns/1ps
`default_nettype none
module acfrx_rx (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic rxLine,
  input wire logic rxEnable,
  input wire logic [1:0] charLen,
  input wire logic parEn,
  input wire logic [1:0] parFmt,
  output logic charValid,
  output logic [7:0] charData,
  output logic parBit,
  output logic parErr,
  output logic frameErr
);
  import acfrx_pkg::*;
  acfrx_rxst_t state_r;
  logic [4:0] cnt_r;
  logic [3:0] idx_r;
  logic [7:0] sh_r;
  logic par_r;
  logic tick;
  logic [3:0] nBits;
  logic [7:0] justified;

  assign tick = cnt_r == 5'h00;
  assign nBits = acfrx_bits(charLen);
  assign justified = sh_r >> (4'h8 - nBits);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_r <= RX_IDLE;
      cnt_r <= 5'h00;
      idx_r <= 4'h0;
      sh_r <= 8'h00;
      par_r <= 1'b0;
      charValid <= 1'b0;
      charData <= 8'h00;
      parBit <= 1'b0;
      parErr <= 1'b0;
      frameErr <= 1'b0;
    end else begin
      charValid <= 1'b0;
      cnt_r <= tick ? BIT_RELOAD : cnt_r - 5'h01;
      unique case (state_r)
        RX_IDLE: begin
          cnt_r <= FIRST_SAMPLE;
          idx_r <= 4'h0;
          if (rxEnable && !rxLine) begin
            state_r <= RX_DATA;
          end
        end
        RX_DATA: if (tick) begin
          sh_r <= {rxLine, sh_r[7:1]};
          idx_r <= idx_r + 4'h1;
          if (idx_r == nBits - 4'h1) begin
            state_r <= parEn ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: if (tick) begin
          par_r <= rxLine;
          state_r <= RX_STOP;
        end
        RX_STOP: if (tick) begin
          charValid <= 1'b1;
          charData <= justified;
          parBit <= parEn & par_r;
          parErr <= parEn && (par_r != acfrx_parity(parFmt, justified));
          frameErr <= !rxLine;
          state_r <= RX_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== acfrx_ctrl.sv ====
/*
  character format and receive fifo control for one async channel, with an
  ahb-lite register slave and a compact transmitter.
  assumes one ahb-lite master, word transfers only, synchronous line inputs.
*/
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - transmitter sends one stop bit when stop select is 0, two when 1
// - parity format picks space, odd, even or mark for send and check
// - short characters carry received parity just above their top data bit
// - status byte bit 0 holds the received parity bit, 0 when parity is disabled
// - parity mismatch sets status bit 7 and may raise a maskable event
// - parity enable switches generation and checking together
// - length code 00..11 gives 8, 7, 6, 5 data bits
// - storage disable keeps parity out of the data byte of short characters
// - fifo status format bit adds one status byte after each data byte
// - status byte: parity error bit 7, framing error bit 6, parity bit 0
// - threshold codes give 1, 4, 16, 32 bytes; 2 with status bytes at code 00
// - threshold reached raises pool-full; host reads then sends message complete
// - enabled termination character match raises the detection event
// - host reads low byte count after detection and masks with threshold-1
// - byte count grows by threshold per pool-full; cleared by complete after detect
// - transmit frame in dma mode issues exactly the block length plus one requests
// - high receive count reads back mode and carrier bits last written
// - upper four receive count bits read zero in async mode
// - transfer mode bit selects interrupt driven or dma driven transfer
// - carrier auto start lets carrier detect enable the receiver
// - message complete frees fifo space and re-enables dma after detection
module acfrx_ctrl (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rxLine,
  input wire logic carrierDetect,
  output logic txLine,
  output logic rxDmaReq,
  output logic txDmaReq,
  output logic poolFullIrq,
  output logic termDetIrq,
  output logic parityErrIrq
);
  import acfrx_pkg::*;

  // register storage
  logic [7:0] dataFormat_r;
  logic [7:0] fifoCtrl_r;
  logic [7:0] termChar_r;
  logic [7:0] irqMask_r;
  logic [7:0] txCountLow_r;
  logic [7:0] txCountHigh_r;
  logic [11:0] rxByteCount_r;
  // bus pipeline
  logic wrPend_r;
  logic [7:0] wrIdx_r;
  // fifo pointers
  logic [FIFO_AW:0] wrPtr_r;
  logic [FIFO_AW:0] rdPtr_r;
  logic [FIFO_AW:0] relPtr_r;
  logic [FIFO_AW:0] poolMark_r;
  logic stsPend_r;
  logic [7:0] stsByte_r;
  logic tcdArm_r;
  logic tcdDue_r;
  logic tcdSeen_r;
  // transmitter
  acfrx_txst_t txState_r;
  logic [7:0] txHold_r;
  logic txHoldFull_r;
  logic [7:0] txShift_r;
  logic [4:0] txCnt_r;
  logic [3:0] txIdx_r;
  logic txPar_r;
  logic txStop2_r;
  logic [12:0] txRemain_r;

  // field decode
  logic stopTwo;
  logic [1:0] parFmt;
  logic parEn;
  logic [1:0] charLen;
  logic dpsBit;
  logic statusFmt;
  logic [1:0] thrCode;
  logic tcdEn;
  logic dmaMode;
  logic casBit;
  logic [11:0] txLength;
  logic [6:0] thrBytes;
  logic [3:0] nBits;
  assign stopTwo = dataFormat_r[DATA_FORMAT_REG_STOP];
  assign parFmt = dataFormat_r[DATA_FORMAT_REG_PAR+:2];
  assign parEn = dataFormat_r[DATA_FORMAT_REG_PARITY_ENABLE_BIT];
  assign charLen = dataFormat_r[DATA_FORMAT_REG_CHL+:2];
  assign dpsBit = fifoCtrl_r[RFC_DPS];
  assign statusFmt = fifoCtrl_r[RFC_FIFO_STATUS_FORMAT];
  assign thrCode = fifoCtrl_r[RFC_RFTH+:2];
  assign tcdEn = fifoCtrl_r[RFC_TERM_CHAR_DETECT_ENABLE];
  assign dmaMode = txCountHigh_r[CNTH_DMA];
  assign casBit = txCountHigh_r[CNTH_CAS];
  assign txLength = {txCountHigh_r[3:0], txCountLow_r};
  assign nBits = acfrx_bits(charLen);
  assign thrBytes = (thrCode == 2'b00) ? (statusFmt ? 7'h02 : 7'h01) :
                    (thrCode == 2'b01) ? 7'h04 : (thrCode == 2'b10) ? 7'h10 : 7'h20;

  // receiver
  logic rxEnable;
  logic charValid;
  logic [7:0] charData;
  logic rxParBit;
  logic rxParErr;
  logic rxFrameErr;
  assign rxEnable = !casBit || carrierDetect;
  acfrx_rx rxUnit (
    .clk_sys(clk_sys),
    .reset(reset),
    .rxLine(rxLine),
    .rxEnable(rxEnable),
    .charLen(charLen),
    .parEn(parEn),
    .parFmt(parFmt),
    .charValid(charValid),
    .charData(charData),
    .parBit(rxParBit),
    .parErr(rxParErr),
    .frameErr(rxFrameErr)
  );

  // byte formatting
  logic keepPar;
  logic [7:0] parAbove;
  logic [7:0] dataByte;
  logic [7:0] statusByte;
  assign keepPar = parEn && (nBits != 4'h8) && !dpsBit;
  assign parAbove = {7'h00, rxParBit} << nBits[2:0];
  assign dataByte = keepPar ? (charData | parAbove) : charData;
  assign statusByte = {rxParErr, rxFrameErr, 5'h00, rxParBit};

  // fifo occupancy
  logic [FIFO_AW:0] used;
  logic [FIFO_AW:0] fill;
  logic [FIFO_AW:0] need;
  logic charAccept;
  logic wrEn;
  logic [7:0] wrData;
  logic lastByte;
  logic poolHit;
  logic tcdFire;
  assign used = wrPtr_r - relPtr_r;
  assign fill = wrPtr_r - poolMark_r;
  assign need = statusFmt ? 7'h02 : 7'h01;
  assign charAccept = charValid && ((FIFO_DEPTH - used) >= need);
  assign wrEn = charAccept || stsPend_r;
  assign wrData = stsPend_r ? stsByte_r : dataByte;
  assign lastByte = (charAccept && !statusFmt) || stsPend_r;
  assign tcdFire = tcdDue_r;
  assign poolHit = !tcdFire && (fill >= thrBytes);

  // bus decode
  logic addrPhase;
  logic [7:0] aIdx;
  logic readFifo;
  logic busWr;
  logic [7:0] wByte;
  logic [7:0] readMux;
  logic [7:0] rdMem;
  logic [FIFO_AW:0] rdPtr_nxt;
  logic rmcCmd;
  logic xfCmd;
  logic txLoad;
  assign addrPhase = hsel && htrans[1] && hready;
  assign aIdx = haddr[9:2];
  assign readFifo = addrPhase && !hwrite && (aIdx == REG_FIFO) && (poolMark_r != rdPtr_r);
  assign rdPtr_nxt = readFifo ? rdPtr_r + 7'h01 : rdPtr_r;
  assign busWr = wrPend_r;
  assign wByte = hwdata[7:0];
  assign rmcCmd = busWr && (wrIdx_r == REG_CMD) && wByte[CMD_RMC];
  assign xfCmd = busWr && (wrIdx_r == REG_CMD) && wByte[CMD_XF];
  assign txLoad = busWr && (wrIdx_r == REG_FIFO) && !txHoldFull_r;
  assign readMux = (aIdx == REG_FIFO) ? rdMem :
                   (aIdx == REG_MASK) ? irqMask_r :
                   (aIdx == REG_STAT) ? {5'h00, txState_r != TX_IDLE, tcdSeen_r, carrierDetect} :
                   (aIdx == REG_TCR) ? termChar_r :
                   (aIdx == REG_DATA_FORMAT_REG) ? dataFormat_r :
                   (aIdx == REG_RFC) ? fifoCtrl_r :
                   (aIdx == REG_CNTL) ? rxByteCount_r[7:0] :
                   (aIdx == REG_CNTH) ? {dmaMode, 1'b0, casBit, 5'h00} :
                   8'h00;

  acfrx_mem fifoMem (
    .clk_sys(clk_sys),
    .reset(reset),
    .wrEn(wrEn),
    .wrAddr(wrPtr_r[FIFO_AW-1:0]),
    .wrData(wrData),
    .rdAddr(rdPtr_nxt[FIFO_AW-1:0]),
    .rdData(rdMem)
  );

  // ahb-lite slave, zero wait states
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wrPend_r <= 1'b0;
      wrIdx_r <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wrPend_r <= addrPhase && hwrite;
      wrIdx_r <= aIdx;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addrPhase && !hwrite) begin
        hrdata <= {24'h00_0000, readMux};
      end
    end
  end

  // writable registers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dataFormat_r <= REG_RESET;
      fifoCtrl_r <= REG_RESET;
      termChar_r <= REG_RESET;
      irqMask_r <= REG_RESET;
      txCountLow_r <= REG_RESET;
      txCountHigh_r <= REG_RESET;
    end else if (busWr) begin
      if (wrIdx_r == REG_DATA_FORMAT_REG) begin
        dataFormat_r <= wByte & DATA_FORMAT_REG_BITS;
      end
      if (wrIdx_r == REG_RFC) begin
        fifoCtrl_r <= wByte & RFC_BITS;
      end
      if (wrIdx_r == REG_TCR) begin
        termChar_r <= wByte;
      end
      if (wrIdx_r == REG_MASK) begin
        irqMask_r <= wByte & MASK_BITS;
      end
      if (wrIdx_r == REG_CNTL) begin
        txCountLow_r <= wByte;
      end
      if (wrIdx_r == REG_CNTH) begin
        txCountHigh_r <= wByte & CNTH_BITS;
      end
    end
  end

  // receive fifo and pool bookkeeping
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wrPtr_r <= 7'h00;
      rdPtr_r <= 7'h00;
      relPtr_r <= 7'h00;
      poolMark_r <= 7'h00;
      stsPend_r <= 1'b0;
      stsByte_r <= 8'h00;
      tcdArm_r <= 1'b0;
      tcdDue_r <= 1'b0;
      tcdSeen_r <= 1'b0;
      rxByteCount_r <= 12'h000;
    end else begin
      rdPtr_r <= rdPtr_nxt;
      if (wrEn) begin
        wrPtr_r <= wrPtr_r + 7'h01;
      end
      stsPend_r <= charAccept && statusFmt;
      if (charAccept) begin
        stsByte_r <= statusByte;
        tcdArm_r <= tcdEn && (charData == termChar_r);
      end
      tcdDue_r <= lastByte && (charAccept ? (tcdEn && (charData == termChar_r)) : tcdArm_r);
      if (rmcCmd) begin
        relPtr_r <= rdPtr_r;
      end
      if (tcdFire) begin
        poolMark_r <= wrPtr_r;
        rxByteCount_r <= rxByteCount_r + {5'h00, fill};
      end else if (poolHit) begin
        poolMark_r <= poolMark_r + thrBytes;
        rxByteCount_r <= rxByteCount_r + {5'h00, thrBytes};
      end else if (rmcCmd && tcdSeen_r) begin
        rxByteCount_r <= 12'h000;
      end
      if (tcdFire) begin
        tcdSeen_r <= 1'b1;
      end else if (rmcCmd) begin
        tcdSeen_r <= 1'b0;
      end
    end
  end

  // event outputs and dma requests
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      poolFullIrq <= 1'b0;
      termDetIrq <= 1'b0;
      parityErrIrq <= 1'b0;
      rxDmaReq <= 1'b0;
      txDmaReq <= 1'b0;
    end else begin
      poolFullIrq <= poolHit && !irqMask_r[MASK_RPF];
      termDetIrq <= tcdFire && !irqMask_r[MASK_TCD];
      parityErrIrq <= charValid && rxParErr && !irqMask_r[MASK_PE];
      rxDmaReq <= dmaMode && (poolMark_r != rdPtr_nxt) && !tcdSeen_r && !tcdFire;
      txDmaReq <= dmaMode && (txRemain_r != 13'h0000) && !txHoldFull_r && !txLoad && !xfCmd;
    end
  end

  // transmitter
  logic txTick;
  assign txTick = txCnt_r == 5'h00;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      txState_r <= TX_IDLE;
      txHold_r <= 8'h00;
      txHoldFull_r <= 1'b0;
      txShift_r <= 8'h00;
      txCnt_r <= 5'h00;
      txIdx_r <= 4'h0;
      txPar_r <= 1'b0;
      txStop2_r <= 1'b0;
      txRemain_r <= 13'h0000;
      txLine <= 1'b1;
    end else begin
      if (xfCmd && dmaMode) begin
        txRemain_r <= {1'b0, txLength} + 13'h0001;
      end else if (txLoad && txRemain_r != 13'h0000) begin
        txRemain_r <= txRemain_r - 13'h0001;
      end
      if (txLoad) begin
        txHold_r <= wByte;
        txHoldFull_r <= 1'b1;
      end
      txCnt_r <= txTick ? BIT_RELOAD : txCnt_r - 5'h01;
      unique case (txState_r)
        TX_IDLE: begin
          txCnt_r <= BIT_RELOAD;
          txLine <= 1'b1;
          if (txHoldFull_r) begin
            txHoldFull_r <= 1'b0;
            txShift_r <= txHold_r;
            txPar_r <= acfrx_parity(parFmt, txHold_r & (8'hFF >> (4'h8 - nBits)));
            txStop2_r <= stopTwo;
            txIdx_r <= 4'h0;
            txLine <= 1'b0;
            txState_r <= TX_START;
          end
        end
        TX_START: if (txTick) begin
          txLine <= txShift_r[0];
          txShift_r <= {1'b0, txShift_r[7:1]};
          txIdx_r <= 4'h1;
          txState_r <= TX_DATA;
        end
        TX_DATA: if (txTick) begin
          if (txIdx_r == nBits) begin
            txLine <= parEn ? txPar_r : 1'b1;
            txState_r <= parEn ? TX_PAR : TX_STOP;
          end else begin
            txLine <= txShift_r[0];
            txShift_r <= {1'b0, txShift_r[7:1]};
            txIdx_r <= txIdx_r + 4'h1;
          end
        end
        TX_PAR: if (txTick) begin
          txLine <= 1'b1;
          txState_r <= TX_STOP;
        end
        TX_STOP: if (txTick) begin
          if (txStop2_r) begin
            txStop2_r <= 1'b0;
          end else begin
            txState_r <= TX_IDLE;
          end
        end
        default: txState_r <= TX_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== acfrx_ctrl_props.sv ====
/*
  port checker for acfrx_ctrl, bound to every acfrx_ctrl instance.
  assumes one clock, word-only ahb-lite writes, hready tied to hreadyout.
*/
`timescale 1ns/1ps
`default_nettype none
module acfrx_ctrl_props (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic txLine,
  input wire logic rxDmaReq,
  input wire logic txDmaReq,
  input wire logic poolFullIrq,
  input wire logic termDetIrq,
  input wire logic parityErrIrq
);
  import acfrx_pkg::*;
  logic wPend_r, dma_r, poolMask_r;
  logic [7:0] wIdx_r;
  wire logic take = hsel & htrans[1] & hready;
  wire logic rdReq = take & ~hwrite;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wPend_r <= 1'b0;
      wIdx_r <= 8'h00;
      dma_r <= 1'b0;
      poolMask_r <= 1'b0;
    end else begin
      wPend_r <= take & hwrite;
      wIdx_r <= haddr[9:2];
      if (wPend_r && wIdx_r == REG_CNTH) dma_r <= hwdata[CNTH_DMA];
      if (wPend_r && wIdx_r == REG_MASK) poolMask_r <= hwdata[MASK_RPF];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_rdata_upper: assert property (hrdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  chk_rdata_hold: assert property (!$past(rdReq) |-> $stable(hrdata))
    else $error("read data changed without a read");
  chk_pool_pulse: assert property (poolFullIrq |=> !poolFullIrq)
    else $error("pool full longer than one cycle");
  chk_term_pulse: assert property (termDetIrq |=> !termDetIrq)
    else $error("termination event longer than one cycle");
  chk_parerr_pulse: assert property (parityErrIrq |=> !parityErrIrq)
    else $error("parity event longer than one cycle");
  chk_pool_masked: assert property (poolMask_r && $past(poolMask_r) |-> !poolFullIrq)
    else $error("masked pool full event seen");
  chk_dma_off: assert property (!dma_r && !$past(dma_r) |-> !txDmaReq && !rxDmaReq)
    else $error("dma request in interrupt mode");
  chk_start_bit: assert property ($fell(txLine) |-> !txLine [*8])
    else $error("start bit too short");
  cov_pool: cover property (poolFullIrq);
  cov_term: cover property (termDetIrq);
  cov_txdma: cover property (txDmaReq);
endmodule
bind acfrx_ctrl acfrx_ctrl_props chk (.clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .txLine(txLine),
  .rxDmaReq(rxDmaReq), .txDmaReq(txDmaReq), .poolFullIrq(poolFullIrq), .termDetIrq(termDetIrq),
  .parityErrIrq(parityErrIrq));
`default_nettype wire

// ==== acfrx_station.sv ====
/*
  remote serial station sending characters on the receive line.
  assumes 16 clocks per bit; line idles high between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module acfrx_station (
  input wire logic clk_sys,
  output logic rxLine
);
  initial rxLine = 1'b1;
  task automatic sendBit(input logic b);
    rxLine <= b;
    repeat (16) @(posedge clk_sys);
  endtask
  task automatic sendChar(input logic [7:0] d, input int nb, input logic hasPar, input logic p);
    sendBit(1'b0);
    for (int i = 0; i < nb; i++) sendBit(d[i]);
    if (hasPar) sendBit(p);
    sendBit(1'b1);
    sendBit(1'b1);
  endtask
endmodule
`default_nettype wire

// ==== test_async_char_format_rx_fifo_ctrl.sv ====
/*
  self-checking bench for acfrx_ctrl.
  assumes acfrx_station drives the receive line and the bench is the bus master.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin totalChecks++; if ((g) !== (e)) begin errCount++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module test_async_char_format_rx_fifo_ctrl;
  import acfrx_pkg::*;
  logic clk_sys, reset, hsel, hwrite, carrierDetect;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hrdata;
  logic hreadyout, hresp, txLine, rxDmaReq, txDmaReq, poolFullIrq, termDetIrq, parityErrIrq;
  wire logic rxLine;
  wire logic hready = hreadyout;
  int errCount, totalChecks, cyc, poolCnt, termCnt, parCnt;
  acfrx_ctrl dut (.clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rxLine(rxLine), .carrierDetect(carrierDetect), .txLine(txLine), .rxDmaReq(rxDmaReq),
    .txDmaReq(txDmaReq), .poolFullIrq(poolFullIrq), .termDetIrq(termDetIrq), .parityErrIrq(parityErrIrq));
  acfrx_station stn (.clk_sys(clk_sys), .rxLine(rxLine));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (poolFullIrq === 1'b1) poolCnt++;
    if (termDetIrq === 1'b1) termCnt++;
    if (parityErrIrq === 1'b1) parCnt++;
    if (cyc == 60000) begin
      errCount++;
      testDone();
    end
  end
  task automatic testDone;
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h00_0000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, wd};
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rdChk(input string nm, input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    `CHK(nm, 32'(e), rd)
  endtask
  task automatic testRegs;
    logic [7:0] idxs [5] = '{REG_RFC, REG_DATA_FORMAT_REG, REG_TCR, REG_MASK, REG_CNTH};
    for (int i = 0; i < 5; i++) rdChk("reset value", idxs[i], 8'h00);
    wr(8'h3F, 8'hFF);
    rdChk("unmapped", 8'h3F, 8'h00);
    wr(REG_RFC, 8'hFF);
    rdChk("fifo control", REG_RFC, 8'h5D);
    wr(REG_CNTH, 8'h3F);
    rdChk("count high", REG_CNTH, 8'h20);
    wr(REG_CNTH, 8'h00);
    $display("test registers done");
  endtask
  task automatic testFormats;
    logic [7:0] dat;
    logic [1:0] len, fmt;
    logic pe, parity_storage_disable, bad, pb;
    int nb, c0, p0;
    for (int k = 0; k < 32; k++) begin
      len = 2'(k);
      fmt = 2'(k / 4);
      pe = k >= 16;
      parity_storage_disable = (k % 3) == 0;
      bad = pe && (k % 5) == 1;
      nb = 8 - len;
      dat = (8'hC3 ^ 8'(k * 29)) & (8'hFF >> len);
      pb = fmt == 2'd3 ? 1'b1 : fmt == 2'd2 ? ^dat : fmt == 2'd1 ? ~^dat : 1'b0;
      pb = pb ^ bad;
      wr(REG_DATA_FORMAT_REG, {3'b000, fmt, pe, len});
      wr(REG_RFC, {1'b0, parity_storage_disable, 6'h10});
      c0 = poolCnt;
      p0 = parCnt;
      stn.sendChar(dat, nb, pe, pb);
      `CHK("pool event", c0 + 1, poolCnt)
      rdChk("data byte", REG_FIFO, dat | ((pe && len != 0 && !parity_storage_disable) ? 8'(pb) << nb : 8'h00));
      rdChk("status byte", REG_FIFO, {bad, 6'h00, pb & pe});
      `CHK("parity event", p0 + int'(bad), parCnt)
      wr(REG_CMD, 8'h80);
    end
    $display("test formats done");
  endtask
  task automatic testThreshold;
    int c0, t0;
    wr(REG_DATA_FORMAT_REG, 8'h00);
    wr(REG_TCR, 8'h5A);
    wr(REG_RFC, 8'h05);
    c0 = poolCnt;
    t0 = termCnt;
    for (int i = 0; i < 4; i++) stn.sendChar(8'h10 + 8'(i), 8, 1'b0, 1'b0);
    `CHK("pool event", c0 + 1, poolCnt)
    rdChk("count low", REG_CNTL, 8'h44);
    for (int i = 0; i < 4; i++) rdChk("pool data", REG_FIFO, 8'h10 + 8'(i));
    wr(REG_CMD, 8'h80);
    stn.sendChar(8'h21, 8, 1'b0, 1'b0);
    stn.sendChar(8'h5A, 8, 1'b0, 1'b0);
    `CHK("term event", t0 + 1, termCnt)
    `CHK("pool event", c0 + 1, poolCnt)
    rdChk("count low", REG_CNTL, 8'h46);
    `CHK("valid bytes", 8'h02, rd[7:0] & 8'h03)
    rdChk("term data", REG_FIFO, 8'h21);
    rdChk("term data", REG_FIFO, 8'h5A);
    wr(REG_CMD, 8'h80);
    rdChk("count low", REG_CNTL, 8'h00);
    wr(REG_MASK, 8'h01);
    wr(REG_RFC, 8'h00);
    stn.sendChar(8'h33, 8, 1'b0, 1'b0);
    `CHK("masked pool", c0 + 1, poolCnt)
    rdChk("count low", REG_CNTL, 8'h01);
    wr(REG_CNTH, 8'h20);
    carrierDetect <= 1'b0;
    stn.sendChar(8'h44, 8, 1'b0, 1'b0);
    rdChk("carrier gate", REG_CNTL, 8'h01);
    carrierDetect <= 1'b1;
    stn.sendChar(8'h45, 8, 1'b0, 1'b0);
    rdChk("carrier open", REG_CNTL, 8'h02);
    wr(REG_CNTH, 8'h00);
    $display("test threshold done");
  endtask
  task automatic testTx;
    logic [11:0] f;
    f = {2'b11, ^8'hA7, 8'hA7, 1'b0};
    wr(REG_DATA_FORMAT_REG, 8'h34);
    wr(REG_FIFO, 8'hA7);
    wr(REG_CMD, 8'h08);
    for (int i = 0; i < 2000 && txLine !== 1'b0; i++) @(posedge clk_sys);
    repeat (7) @(posedge clk_sys);
    for (int b = 0; b < 12; b++) begin
      `CHK("tx bit", f[b], txLine)
      repeat (16) @(posedge clk_sys);
    end
    $display("test transmit done");
  endtask
  task automatic testDma;
    int n, idle;
    n = 0;
    idle = 0;
    wr(REG_DATA_FORMAT_REG, 8'h00);
    wr(REG_CNTH, 8'h80);
    wr(REG_CNTL, 8'h02);
    rdChk("count high", REG_CNTH, 8'h80);
    `CHK("rx dma request", 1'b1, rxDmaReq)
    rdChk("rx dma data", REG_FIFO, 8'h33);
    rdChk("rx dma data", REG_FIFO, 8'h45);
    `CHK("rx dma request", 1'b0, rxDmaReq)
    wr(REG_CMD, 8'h08);
    while (idle < 3000) begin
      if (txDmaReq === 1'b1) begin
        wr(REG_FIFO, 8'(n));
        n++;
        idle = 0;
      end else begin
        idle++;
      end
      @(posedge clk_sys);
    end
    `CHK("dma requests", 3, n)
    $display("test dma done");
  endtask
  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    carrierDetect = 1'b1;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    testRegs();
    testFormats();
    testThreshold();
    testTx();
    testDma();
    testDone();
  end
endmodule
`default_nettype wire
